/* pmc_cfg.svh */
// Constants for the power mode controller: mode codes, widths, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Mode request and report codes (2 bits)
`define PMC_MODE_RUN    2'h0
`define PMC_MODE_IDLE   2'h1
`define PMC_MODE_SLEEP  2'h2
`define PMC_MODE_DEEP   2'h3

// Default counts
`define PMC_NUM_PERIPH  8
`define PMC_NUM_UNITS   4
`define PMC_DRAIN_CYC   4
`define PMC_UNIT_IDLE   16

`endif

/* pmc_pkg.sv */
// Types shared by the power mode controller files.
// Assumes pmc_cfg.svh is on the include path.
package pmc_pkg;
  `include "pmc_cfg.svh"

  // Software-visible mode code
  typedef logic [1:0] pmc_mode_t;

  // Power mode sequencer states
  typedef enum logic [2:0] {
    PMC_ST_RUN,
    PMC_ST_IDLE,
    PMC_ST_SUSPEND,
    PMC_ST_SLEEP,
    PMC_ST_STOPCLK,
    PMC_ST_DEEP
  } pmc_state_t;
endpackage

/* pmc_unit_gate.sv */
// Automatic clock gate request for one operating unit.
// Assumes busy comes from logic on core_clk; no crossing needed.
`include "pmc_cfg.svh"

module pmc_unit_gate #(
  parameter int IDLE_CYC = `PMC_UNIT_IDLE
) (
  // Clock, reset, enable
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Unit activity and gate result
  input  wire logic unit_busy,
  output logic      unit_clk_on
);
  import pmc_pkg::*;

  localparam int CW = $clog2(IDLE_CYC + 1);

  // Whole state of the gate
  typedef struct packed {
    logic [CW-1:0] idle_cnt; // Idle cycles seen so far
    logic          on;       // Unit clock enabled
  } pmc_gate_t;

  pmc_gate_t st;      // Registered state
  pmc_gate_t next_st; // Next state

  // R12 shut idle units automatically
  always_comb begin
    next_st = st;
    if (unit_busy) begin
      // Busy wakes the unit at once
      next_st.on       = 1'b1;
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt == CW'(IDLE_CYC)) begin
      // Hysteresis avoids toggling on short gaps
      next_st.on = 1'b0;
    end else begin
      next_st.idle_cnt = st.idle_cnt + CW'(1);
    end
  end

  // State register; units start clocked
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st.idle_cnt <= '0;
      st.on       <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign unit_clk_on = st.on | unit_busy;

  // Idle timeout turns the unit off
  a_gate_idle_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
    (clk_en && !unit_busy && st.idle_cnt == CW'(IDLE_CYC)) |=> !st.on)
    else $error("unit gate did not close after idle timeout");
endmodule

/* pmc_ctrl.sv */
// Power mode controller: run, idle, sleep and deep sleep sequencing.
// Assumes all inputs except nmi_pin and restart_pin are on core_clk;
// those two are pins and are synchronised here.
`include "pmc_cfg.svh"

// Operation
// R1 - Four modes, software selects one
// R2 - Run: all clocks as configured
// R3 - Idle: CPU clock off until wake
// R4 - Software idles only with no tasks; the controller takes any idle request made in run
// R5 - Memory stays reachable during idle
// R6 - Idle wakes: reset, watchdog, NMI, interrupt
// R7 - Sleep clocks only sleep-enabled peripherals
// R8 - Sleep asserts suspend to other peripherals
// R9 - Sleep wakes: peripheral irq, watchdog, NMI
// R10 - Orderly shutdown into sleep states
// R11 - Deep sleep: clock off, external restart
// R12 - Idle units gated off automatically
// R13 - Wake restores clocks, suspend, run mode
module pmc_ctrl #(
  parameter int NPER   = `PMC_NUM_PERIPH,
  parameter int NUNIT  = `PMC_NUM_UNITS,
  parameter int DRAIN  = `PMC_DRAIN_CYC
) (
  // Clock, reset, enable
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  // Software mode request
  input  wire logic            mode_req,
  input  wire pmc_pkg::pmc_mode_t mode_sel,
  output pmc_pkg::pmc_mode_t   mode_now,
  output logic                 mode_busy,
  // Wake sources
  input  wire logic            wdt_event,
  input  wire logic            nmi_pin,
  input  wire logic            irq_pending,
  input  wire logic [NPER-1:0] periph_irq,
  input  wire logic            restart_pin,
  // Peripheral side
  input  wire logic [NPER-1:0] sleep_en,
  input  wire logic [NPER-1:0] periph_quiet,
  output logic [NPER-1:0]      periph_clk_en,
  output logic [NPER-1:0]      periph_suspend,
  // Core and clock distribution
  output logic                 cpu_clk_en,
  output logic                 sys_clk_en,
  output logic                 mem_access_en,
  // Operating units
  input  wire logic [NUNIT-1:0] unit_busy,
  output logic [NUNIT-1:0]     unit_clk_en
);
  import pmc_pkg::*;

  localparam int DW = $clog2(DRAIN + 1);

  // Whole state of the controller
  typedef struct packed {
    pmc_state_t    fsm;      // power_mode_fsm state
    logic [DW-1:0] drain;    // Shutdown drain counter
    logic [1:0]    nmi_sync; // NMI pin synchroniser
    logic          nmi_prev; // Last synced NMI level
    logic [1:0]    rst_sync; // Restart pin synchroniser
    pmc_mode_t     mode;     // Reported mode
    logic          cpu_on;   // CPU clock enable
    logic          sys_on;   // System clock enable
    logic [NPER-1:0] susp;   // Suspend per peripheral
  } pmc_ctrl_st_t;

  pmc_ctrl_st_t st;      // Registered state
  pmc_ctrl_st_t next_st; // Next state

  logic nmi_fall;   // Falling edge of synced NMI
  logic restart;    // Synced restart level
  logic wake_idle;  // Idle wake condition
  logic wake_sleep; // Sleep wake condition
  logic all_quiet;  // Suspended peripherals idle

  // Wake decode shared by idle and sleep
  function automatic logic wake_any(input logic wdt, input logic nmi, input logic irq);
    wake_any = wdt | nmi | irq;
  endfunction

  // NMI second stage feeds edge logic; restart second stage is used as a level
  assign nmi_fall  = st.nmi_prev & ~st.nmi_sync[1];
  assign restart   = st.rst_sync[1];
  // R6 idle wake sources
  assign wake_idle = wake_any(wdt_event, nmi_fall, irq_pending);
  // R9 sleep wake sources, operating peripherals only
  assign wake_sleep = wake_any(wdt_event, nmi_fall, |(periph_irq & sleep_en));
  assign all_quiet  = &(periph_quiet | sleep_en);

  // Next-state logic of power_mode_fsm
  always_comb begin
    next_st          = st;
    next_st.nmi_sync = {st.nmi_sync[0], nmi_pin};
    next_st.nmi_prev = st.nmi_sync[1];
    next_st.rst_sync = {st.rst_sync[0], restart_pin};
    case (st.fsm)
      PMC_ST_RUN: begin
        // R2 everything on in run
        next_st.cpu_on = 1'b1;
        next_st.sys_on = 1'b1;
        next_st.susp   = '0;
        next_st.mode   = `PMC_MODE_RUN;
        // R1 software selects the mode
        if (mode_req) begin
          case (mode_sel)
            `PMC_MODE_IDLE: begin
              // R3 stop only the CPU clock
              next_st.fsm    = PMC_ST_IDLE;
              next_st.cpu_on = 1'b0;
              next_st.mode   = `PMC_MODE_IDLE;
            end
            `PMC_MODE_SLEEP, `PMC_MODE_DEEP: begin
              // R10 suspend first, then drain
              next_st.fsm   = PMC_ST_SUSPEND;
              next_st.susp  = ~sleep_en;
              next_st.drain = '0;
              next_st.mode  = mode_sel;
            end
            default: begin
              // Run request while in run: no change
              next_st.fsm = PMC_ST_RUN;
            end
          endcase
        end
      end
      PMC_ST_IDLE: begin
        // R13 wake back to run
        if (wake_idle) begin
          next_st.fsm    = PMC_ST_RUN;
          next_st.cpu_on = 1'b1;
          next_st.mode   = `PMC_MODE_RUN;
        end
      end
      PMC_ST_SUSPEND: begin
        // R10 wait for quiet peripherals and drain time
        if (wake_sleep) begin
          next_st.fsm    = PMC_ST_RUN;
          next_st.susp   = '0;
          next_st.mode   = `PMC_MODE_RUN;
        end else if (all_quiet && st.drain >= DW'(DRAIN)) begin
          next_st.cpu_on = 1'b0;
          next_st.fsm    = (st.mode == `PMC_MODE_DEEP) ? PMC_ST_STOPCLK : PMC_ST_SLEEP;
        end else if (st.drain < DW'(DRAIN)) begin
          next_st.drain = st.drain + DW'(1);
        end
      end
      PMC_ST_SLEEP: begin
        // R13 wake from sleep
        if (wake_sleep) begin
          next_st.fsm    = PMC_ST_RUN;
          next_st.cpu_on = 1'b1;
          next_st.susp   = '0;
          next_st.mode   = `PMC_MODE_RUN;
        end
      end
      PMC_ST_STOPCLK: begin
        // R11 last step: stop system clock
        next_st.sys_on = 1'b0;
        next_st.susp   = '1;
        next_st.fsm    = PMC_ST_DEEP;
      end
      PMC_ST_DEEP: begin
        // R11 only the external restart wakes
        if (restart) begin
          next_st.fsm    = PMC_ST_RUN;
          next_st.sys_on = 1'b1;
          next_st.cpu_on = 1'b1;
          next_st.susp   = '0;
          next_st.mode   = `PMC_MODE_RUN;
        end
      end
      default: begin
        // Unknown state recovers to run
        next_st.fsm = PMC_ST_RUN;
      end
    endcase
  end

  // State register; reset is itself a wake into run
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st.fsm      <= PMC_ST_RUN;
      st.drain    <= '0;
      st.nmi_sync <= 2'h3;
      st.nmi_prev <= 1'b1;
      st.rst_sync <= 2'h0;
      st.mode     <= `PMC_MODE_RUN;
      st.cpu_on   <= 1'b1;
      st.sys_on   <= 1'b1;
      st.susp     <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs from state
  assign mode_now       = st.mode;
  assign mode_busy      = (st.fsm == PMC_ST_SUSPEND) || (st.fsm == PMC_ST_STOPCLK);
  assign cpu_clk_en     = st.cpu_on;
  assign sys_clk_en     = st.sys_on;
  // R5 memory reachable unless system clock stopped
  assign mem_access_en  = st.sys_on;
  // R8 suspend the non-sleep peripherals
  assign periph_suspend = st.susp;
  // R7 clocks follow suspend and system clock
  assign periph_clk_en  = {NPER{st.sys_on}} & ~st.susp;

  // R12 one automatic gate per unit
  genvar gi;
  generate
    for (gi = 0; gi < NUNIT; gi++) begin : g_unit
      logic gate_on;
      pmc_unit_gate u_gate (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .unit_busy   (unit_busy[gi]),
        .unit_clk_on (gate_on)
      );
      assign unit_clk_en[gi] = gate_on & st.sys_on;
    end
  endgenerate

  a_idle_cpu_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    (st.fsm == PMC_ST_IDLE) |-> (!cpu_clk_en && sys_clk_en && periph_suspend == '0))
    else $error("idle mode clocks wrong");
  a_idle_wake_run: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    (clk_en && st.fsm == PMC_ST_IDLE && wake_idle) |=> (mode_now == `PMC_MODE_RUN && cpu_clk_en))
    else $error("idle wake missed");
  a_sleep_suspend: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    (st.fsm == PMC_ST_SLEEP) |-> (periph_suspend == ~sleep_en && periph_clk_en == sleep_en))
    else $error("sleep suspend wrong");
  a_sleep_wake_run: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    (clk_en && st.fsm == PMC_ST_SLEEP && wake_sleep) |=> (st.fsm == PMC_ST_RUN && periph_suspend == '0))
    else $error("sleep wake missed");
  a_orderly_entry: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    (st.fsm == PMC_ST_RUN) |=> (st.fsm != PMC_ST_SLEEP && st.fsm != PMC_ST_DEEP))
    else $error("abrupt entry into sleep");
  a_deep_clk_off: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    (st.fsm == PMC_ST_DEEP && !restart) |-> (!sys_clk_en && unit_clk_en == '0))
    else $error("deep sleep clock running");
  a_run_all_on: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    (st.fsm == PMC_ST_RUN) |-> (cpu_clk_en && sys_clk_en && periph_suspend == '0))
    else $error("run mode clocks wrong");
  a_mode_select: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    (clk_en && st.fsm == PMC_ST_RUN && mode_req && mode_sel == `PMC_MODE_IDLE) |=> (st.fsm == PMC_ST_IDLE))
    else $error("idle request ignored");
  a_mem_in_idle: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    (st.fsm == PMC_ST_IDLE) |-> mem_access_en)
    else $error("memory blocked in idle");
  a_wake_restore: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
    (clk_en && st.fsm == PMC_ST_DEEP && restart) |=> (sys_clk_en && cpu_clk_en && mode_now == `PMC_MODE_RUN))
    else $error("restart did not restore run");
endmodule

/* pmc_far_model.sv */
// Far side model: peripherals that drain after suspend, units that work.
// Assumes the controller's core_clk and its synchronous reset.
module pmc_far_model #(
  parameter int NPER  = 8,
  parameter int NUNIT = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Controller outputs seen, and unit work from the bench
  input  wire logic [NPER-1:0]  periph_suspend,
  input  wire logic             cpu_clk_en,
  input  wire logic [NUNIT-1:0] unit_work,
  // Answers to the controller
  output logic [NPER-1:0]       periph_quiet,
  output logic [NUNIT-1:0]      unit_busy
);
  logic [NPER-1:0] drain;  // Transfer still finishing

  // Quiet only two cycles after suspend, so the drain wait is really used
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drain        <= '0;
      periph_quiet <= '0;
    end else begin
      drain        <= periph_suspend;
      periph_quiet <= drain & periph_suspend;
    end
  end

  // Units can only be busy while the CPU clock runs
  assign unit_busy = unit_work & {NUNIT{cpu_clk_en}};
endmodule

/* tb.sv */
// Self-checking bench for the power mode controller.
// Assumes pmc_pkg and pmc_far_model compiled before it.
`include "pmc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  logic       core_clk, sys_rst, clk_en, mode_req, mode_busy;
  logic       wdt_event, nmi_pin, irq_pending, restart_pin;
  logic       cpu_clk_en, sys_clk_en, mem_access_en;
  pmc_mode_t  mode_sel, mode_now;
  logic [7:0] periph_irq, sleep_en, periph_quiet, periph_clk_en, periph_suspend;
  logic [3:0] unit_busy, unit_clk_en, unit_work;
  int         errors, check_count;
  // One row: requested mode, wake source, expected outputs while asleep
  typedef struct packed {
    pmc_mode_t  sel;
    logic [2:0] wake;
    logic       cpu;
    logic       sys;
    logic [7:0] susp;
  } pmc_row_t;
  pmc_row_t rows [7] = '{'{2'h1, 3'h0, 1'b0, 1'b1, 8'h00}, '{2'h1, 3'h1, 1'b0, 1'b1, 8'h00},
    '{2'h1, 3'h2, 1'b0, 1'b1, 8'h00}, '{2'h2, 3'h3, 1'b0, 1'b1, 8'hf0}, '{2'h2, 3'h1, 1'b0, 1'b1, 8'hf0},
    '{2'h2, 3'h2, 1'b0, 1'b1, 8'hf0}, '{2'h3, 3'h4, 1'b0, 1'b0, 8'hff}};

  pmc_ctrl pmc_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .mode_req(mode_req),
    .mode_sel(mode_sel), .mode_now(mode_now), .mode_busy(mode_busy), .wdt_event(wdt_event),
    .nmi_pin(nmi_pin), .irq_pending(irq_pending), .periph_irq(periph_irq), .restart_pin(restart_pin),
    .sleep_en(sleep_en), .periph_quiet(periph_quiet), .periph_clk_en(periph_clk_en),
    .periph_suspend(periph_suspend), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .mem_access_en(mem_access_en), .unit_busy(unit_busy), .unit_clk_en(unit_clk_en));
  pmc_far_model pmc_far_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .periph_suspend(periph_suspend),
    .cpu_clk_en(cpu_clk_en), .unit_work(unit_work), .periph_quiet(periph_quiet), .unit_busy(unit_busy));

  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait until the mode is reached and the sequencer is quiet
  task automatic settle(input pmc_mode_t m);
    int n;
    n = 0;
    while (!(mode_now === m && mode_busy === 1'b0) && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    repeat (2) @(negedge core_clk);
    chk(8'(mode_now), 8'(m));
  endtask
  // Clock and suspend outputs against the expected picture
  task automatic outs(input logic cpu, input logic sys, input logic [7:0] susp);
    chk(8'(cpu_clk_en), 8'(cpu));
    chk(8'(sys_clk_en), 8'(sys));
    chk(8'(mem_access_en), 8'(sys));
    chk(periph_suspend, susp);
    chk(periph_clk_en, ~susp & {8{sys}});
  endtask
  task automatic request(input pmc_mode_t m);
    @(posedge core_clk);
    mode_sel <= m;
    mode_req <= 1'b1;
    @(posedge core_clk);
    mode_req <= 1'b0;
  endtask
  // Raise one wake source, expect run, then drop every source again
  task automatic wake(input logic [2:0] w);
    @(posedge core_clk);
    case (w)
      3'h0: irq_pending <= 1'b1;
      3'h1: wdt_event <= 1'b1;
      3'h2: nmi_pin <= 1'b0;
      3'h3: periph_irq <= 8'h01;
      default: restart_pin <= 1'b1;
    endcase
    settle(`PMC_MODE_RUN);
    outs(1'b1, 1'b1, 8'h00);
    @(posedge core_clk);
    {irq_pending, wdt_event, restart_pin} <= 3'h0;
    nmi_pin <= 1'b1;
    periph_irq <= 8'h00;
  endtask
  task automatic print_verdict();
    $display("Counts: checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #100us;
    errors++;
    print_verdict();
  end

  initial begin
    {sys_rst, clk_en, nmi_pin} = 3'h7;
    {mode_req, wdt_event, irq_pending, restart_pin} = 4'h0;
    mode_sel = `PMC_MODE_RUN;
    {periph_irq, unit_work} = '0;
    sleep_en = 8'h0f;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    outs(1'b1, 1'b1, 8'h00);
    chk(8'(unit_clk_en), 8'h0f);
    $display("Test reset done");
    // each low-power mode with each of its wake sources but reset
    foreach (rows[i]) begin
      request(rows[i].sel);
      settle(rows[i].sel);
      outs(rows[i].cpu, rows[i].sys, rows[i].susp);
      wake(rows[i].wake);
      $display("Test row %0d done", i);
    end
    // Requests outside run are refused, frozen clock holds idle
    request(`PMC_MODE_RUN);
    settle(`PMC_MODE_RUN);
    request(`PMC_MODE_IDLE);
    settle(`PMC_MODE_IDLE);
    request(`PMC_MODE_SLEEP);
    settle(`PMC_MODE_IDLE);
    @(posedge core_clk);
    clk_en <= 1'b0;
    irq_pending <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk(8'(mode_now), 8'(`PMC_MODE_IDLE));
    @(posedge core_clk);
    clk_en <= 1'b1;
    settle(`PMC_MODE_RUN);
    @(posedge core_clk);
    irq_pending <= 1'b0;
    $display("Test refuse done");
    // Deep sleep ignores every source but restart
    request(`PMC_MODE_DEEP);
    settle(`PMC_MODE_DEEP);
    @(posedge core_clk);
    {irq_pending, wdt_event, nmi_pin} <= 3'h6;
    periph_irq <= 8'hff;
    repeat (12) @(negedge core_clk);
    chk(8'(mode_now), 8'(`PMC_MODE_DEEP));
    chk(8'(sys_clk_en), 8'h00);
    wake(3'h4);
    $display("Test deep done");
    // Wake in mid shutdown aborts back to run
    request(`PMC_MODE_SLEEP);
    @(negedge core_clk);
    chk(8'(mode_busy), 8'h01);
    @(posedge core_clk);
    wdt_event <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(8'(mode_now), 8'(`PMC_MODE_RUN));
    wake(3'h1);
    $display("Test abort done");
    // Idle units gated off, busy units on at once
    @(posedge core_clk);
    unit_work <= 4'h1;
    repeat (40) @(negedge core_clk);
    chk(8'(unit_clk_en), 8'h01);
    @(posedge core_clk);
    unit_work <= 4'h3;
    @(negedge core_clk);
    chk(8'(unit_clk_en), 8'h03);
    $display("Test units done");
    // Reset in mid-run wakes idle and sleep straight into run
    for (int k = 1; k < 3; k++) begin
      request(pmc_mode_t'(k));
      settle(pmc_mode_t'(k));
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      chk(8'(mode_now), 8'(`PMC_MODE_RUN));
      outs(1'b1, 1'b1, 8'h00);
      chk(8'(unit_clk_en), 8'h0f);
    end
    $display("Test reset wake done");
    print_verdict();
  end
endmodule
